// ---- inc/srcr_defs.vh ----
// Register map and field constants of the SYSREF control register bank
`ifndef SRCR_DEFS_VH
`define SRCR_DEFS_VH

`define SRCR_ADDR_W          7
`define SRCR_OFF_PWR_DIV     7'h18
`define SRCR_OFF_BIAS_SYNC   7'h19
`define SRCR_OFF_PULSE_CNT   7'h1A
`define SRCR_OFF_PHASE_DLY   7'h1B
`define SRCR_OFF_MODE        7'h1C
`define SRCR_OFF_EXTRA       7'h70

`define SRCR_BIT_PWR_DOWN    7
`define SRCR_BIT_BIAS        7
`define SRCR_BIT_EXTRA       7
`define SRCR_BIT_GEN         1
`define SRCR_BIT_OUT         0
`define SRCR_MASK_MODE       8'h03
`define SRCR_MASK_EXTRA      8'h80

`define SRCR_RST_PWR_DIV     8'h2F
`define SRCR_RST_BIAS_SYNC   8'h80
`define SRCR_RST_PULSE_CNT   8'h00
`define SRCR_RST_PHASE_DLY   8'h00
`define SRCR_RST_MODE        8'h00
`define SRCR_RST_EXTRA       8'h00
`define SRCR_RST_LOCK_MASK   1'b0
`define SRCR_RST_RDATA       8'h00
`define SRCR_RST_LOCK_FAIL   1'b0

`endif

// ---- rtl/srcr_div_ratio.v ----
// Decodes the seven-bit SYSREF divider field into its total ratio
`timescale 1ns/1ps
module srcr_div_ratio (
    input  wire        clk_sys,     // System clock
    input  wire        rst_b,       // Asynchronous reset, active low
    input  wire [6:0]  div_field,   // Divider field
    output reg  [12:0] div_ratio_r  // Product of the four sub-dividers
);
    reg [2:0]  s6;
    reg [4:0]  s54;
    reg [4:0]  s32;
    reg [2:0]  s10;
    reg [21:0] prod;

    // RQ7 sub-divider encodings
    always @* begin
        s6  = div_field[6] ? 3'h4 : 3'h2;
        s54 = 5'h02 << div_field[5:4];
        s32 = 5'h02 << div_field[3:2];
        s10 = 3'h2 + {1'b0, div_field[1:0]};
        prod = {19'h0, s6} * {17'h0, s54} * {17'h0, s32} * {19'h0, s10};
    end

    // RQ4 product of ratios
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_ratio_r <= 13'h0000;
        end else begin
            // Largest ratio is 5120, which needs all thirteen bits
            div_ratio_r <= prod[12:0];
        end
    end
endmodule // srcr_div_ratio

// ---- rtl/srcr_regs.v ----
// SYSREF control register bank with lock-indicator masking
//
// What this block does
// RQ1: Mask set: only VCXO loss fails lock
// RQ2: Mask clear: reference inactivity also fails lock
// RQ3: Power-down bit 0 powers up, resets 0
// RQ4: SYSREF divide equals product of four sub-dividers
// RQ5: Divider field resets to 0101111
// RQ6: Register addresses and bit placements as mapped
// RQ7: Sub-divider encodings 2/4, 2-16, 2-5
// RQ8: Reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "srcr_defs.vh"
module srcr_regs (
    input  wire        clk_sys,              // System clock, 25 MHz
    input  wire        rst_b,                // Async reset, active low
    input  wire        cfg_wr,               // Write strobe, one cycle
    input  wire        cfg_rd,               // Read strobe, one cycle
    input  wire [6:0]  cfg_addr,             // Register address
    input  wire [7:0]  cfg_wdata,            // Write data
    output reg  [7:0]  cfg_rdata_r,          // Read data, next cycle
    input  wire        ref_loss_lock_mask,   // Reference-loss mask bit
    input  wire        vcxo_loop_lock_loss,  // VCXO loop lost lock
    input  wire        sel_ref_inactive,     // Selected ref inactive
    output reg         lock_fail_r,          // Lock failure indication
    output reg         sysref_power_down_r,  // SYSREF blocks powered down
    output reg  [6:0]  sysref_divider_r,     // Divider field
    output wire [12:0] sysref_div_ratio_r,   // Total divide ratio
    output reg         bias_sel_r,           // Output bias select
    output reg  [6:0]  sync_r,               // Sync field
    output reg  [7:0]  sysref_pulse_count_r, // Pulse count
    output reg  [7:0]  phase_delay_r,        // Global phase delay
    output reg         sysref_gen_bit_r,     // Generator mode bit
    output reg         sysref_out_bit_r,     // Output mode bit
    output reg         sysref_extra_bit_r    // Extra control bit
);
    // Reset images as sized words; each field is then a plain part-select
    localparam [7:0] RST_PWR_DIV   = `SRCR_RST_PWR_DIV;
    localparam [7:0] RST_BIAS_SYNC = `SRCR_RST_BIAS_SYNC;
    localparam [7:0] RST_PULSE_CNT = `SRCR_RST_PULSE_CNT;
    localparam [7:0] RST_PHASE_DLY = `SRCR_RST_PHASE_DLY;
    localparam [7:0] RST_MODE      = `SRCR_RST_MODE;
    localparam [7:0] RST_EXTRA     = `SRCR_RST_EXTRA;

    // Address hits and per-register write strobes
    wire       hit_pwr_div;            // 0x18 addressed
    wire       hit_bias_sync;          // 0x19 addressed
    wire       hit_pulse_cnt;          // 0x1A addressed
    wire       hit_phase_dly;          // 0x1B addressed
    wire       hit_mode;               // 0x1C addressed
    wire       hit_extra;              // 0x70 addressed
    wire       wr_pwr_div;             // Write to 0x18
    wire       wr_bias_sync;           // Write to 0x19
    wire       wr_pulse_cnt;           // Write to 0x1A
    wire       wr_phase_dly;           // Write to 0x1B
    wire       wr_mode;                // Write to 0x1C
    wire       wr_extra;               // Write to 0x70

    // Next values of every register
    reg        sysref_power_down_nxt;  // Power-down bit
    reg  [6:0] sysref_divider_nxt;     // Divider field
    reg        bias_sel_nxt;           // Bias select
    reg  [6:0] sync_nxt;               // Sync field
    reg  [7:0] sysref_pulse_count_nxt; // Pulse count
    reg  [7:0] phase_delay_nxt;        // Global phase delay
    reg        sysref_gen_bit_nxt;     // Generator mode bit
    reg        sysref_out_bit_nxt;     // Output mode bit
    reg        sysref_extra_bit_nxt;   // Extra control bit
    reg  [7:0] rd_nxt;                 // Addressed register image
    reg  [7:0] cfg_rdata_nxt;          // Read data register input
    reg        lock_fail_nxt;          // Lock failure input

    assign hit_pwr_div   = (cfg_addr == `SRCR_OFF_PWR_DIV);
    assign hit_bias_sync = (cfg_addr == `SRCR_OFF_BIAS_SYNC);
    assign hit_pulse_cnt = (cfg_addr == `SRCR_OFF_PULSE_CNT);
    assign hit_phase_dly = (cfg_addr == `SRCR_OFF_PHASE_DLY);
    assign hit_mode      = (cfg_addr == `SRCR_OFF_MODE);
    assign hit_extra     = (cfg_addr == `SRCR_OFF_EXTRA);

    // RQ6 unmapped writes hit nothing
    assign wr_pwr_div    = cfg_wr & hit_pwr_div;
    assign wr_bias_sync  = cfg_wr & hit_bias_sync;
    assign wr_pulse_cnt  = cfg_wr & hit_pulse_cnt;
    assign wr_phase_dly  = cfg_wr & hit_phase_dly;
    assign wr_mode       = cfg_wr & hit_mode;
    assign wr_extra      = cfg_wr & hit_extra;

    // RQ4 ratio decode kept registered so the output is a flop
    srcr_div_ratio u_ratio (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .div_field   (sysref_divider_r),
        .div_ratio_r (sysref_div_ratio_r)
    );

    // RQ3 power-down write
    always @* begin
        sysref_power_down_nxt = sysref_power_down_r;
        sysref_divider_nxt    = sysref_divider_r;
        if (wr_pwr_div) begin
            sysref_power_down_nxt = cfg_wdata[`SRCR_BIT_PWR_DOWN];
            sysref_divider_nxt    = cfg_wdata[6:0];
        end
    end

    // RQ6 bias and sync
    always @* begin
        bias_sel_nxt = bias_sel_r;
        sync_nxt     = sync_r;
        if (wr_bias_sync) begin
            bias_sel_nxt = cfg_wdata[`SRCR_BIT_BIAS];
            sync_nxt     = cfg_wdata[6:0];
        end
    end

    // RQ6 full-byte fields
    always @* begin
        sysref_pulse_count_nxt = sysref_pulse_count_r;
        phase_delay_nxt        = phase_delay_r;
        if (wr_pulse_cnt) begin
            sysref_pulse_count_nxt = cfg_wdata;
        end
        if (wr_phase_dly) begin
            phase_delay_nxt = cfg_wdata;
        end
    end

    // RQ8 reserved bits dropped
    always @* begin
        sysref_gen_bit_nxt   = sysref_gen_bit_r;
        sysref_out_bit_nxt   = sysref_out_bit_r;
        sysref_extra_bit_nxt = sysref_extra_bit_r;
        if (wr_mode) begin
            sysref_gen_bit_nxt = cfg_wdata[`SRCR_BIT_GEN];
            sysref_out_bit_nxt = cfg_wdata[`SRCR_BIT_OUT];
        end
        if (wr_extra) begin
            sysref_extra_bit_nxt = cfg_wdata[`SRCR_BIT_EXTRA];
        end
    end

    // RQ3 power-down resets clear
    // RQ5 divider reset pattern
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sysref_power_down_r <= RST_PWR_DIV[`SRCR_BIT_PWR_DOWN];
            sysref_divider_r    <= RST_PWR_DIV[6:0];
        end else begin
            sysref_power_down_r <= sysref_power_down_nxt;
            sysref_divider_r    <= sysref_divider_nxt;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bias_sel_r <= RST_BIAS_SYNC[`SRCR_BIT_BIAS];
            sync_r     <= RST_BIAS_SYNC[6:0];
        end else begin
            bias_sel_r <= bias_sel_nxt;
            sync_r     <= sync_nxt;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sysref_pulse_count_r <= RST_PULSE_CNT;
            phase_delay_r        <= RST_PHASE_DLY;
        end else begin
            sysref_pulse_count_r <= sysref_pulse_count_nxt;
            phase_delay_r        <= phase_delay_nxt;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sysref_gen_bit_r   <= RST_MODE[`SRCR_BIT_GEN];
            sysref_out_bit_r   <= RST_MODE[`SRCR_BIT_OUT];
            sysref_extra_bit_r <= RST_EXTRA[`SRCR_BIT_EXTRA];
        end else begin
            sysref_gen_bit_r   <= sysref_gen_bit_nxt;
            sysref_out_bit_r   <= sysref_out_bit_nxt;
            sysref_extra_bit_r <= sysref_extra_bit_nxt;
        end
    end

    // RQ8 reserved and unmapped read zero
    always @* begin
        case (cfg_addr)
            `SRCR_OFF_PWR_DIV:   rd_nxt = {sysref_power_down_r,
                                           sysref_divider_r};
            `SRCR_OFF_BIAS_SYNC: rd_nxt = {bias_sel_r, sync_r};
            `SRCR_OFF_PULSE_CNT: rd_nxt = sysref_pulse_count_r;
            `SRCR_OFF_PHASE_DLY: rd_nxt = phase_delay_r;
            `SRCR_OFF_MODE:      rd_nxt = {6'h00, sysref_gen_bit_r,
                                           sysref_out_bit_r};
            `SRCR_OFF_EXTRA:     rd_nxt = {sysref_extra_bit_r, 7'h00};
            default:             rd_nxt = 8'h00;
        endcase
    end

    // Data held between reads so a slow port can sample late
    always @* begin
        cfg_rdata_nxt = cfg_rdata_r;
        if (cfg_rd) begin
            cfg_rdata_nxt = rd_nxt;
        end
    end

    // RQ1 mask blocks reference loss
    // RQ2 unmasked reference loss fails lock
    always @* begin
        lock_fail_nxt = vcxo_loop_lock_loss |
                        (~ref_loss_lock_mask & sel_ref_inactive);
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata_r <= `SRCR_RST_RDATA;
            lock_fail_r <= `SRCR_RST_LOCK_FAIL;
        end else begin
            cfg_rdata_r <= cfg_rdata_nxt;
            lock_fail_r <= lock_fail_nxt;
        end
    end
endmodule // srcr_regs

// ---- tb/srcr_regs_monitor.sv ----
// Port assertions for the SYSREF control register bank
`timescale 1ns/1ps
module srcr_regs_monitor (
    input wire        clk_sys,             // System clock
    input wire        rst_b,               // Async reset, active low
    input wire        cfg_wr,              // Write strobe
    input wire        cfg_rd,              // Read strobe
    input wire [6:0]  cfg_addr,            // Register address
    input wire [7:0]  cfg_wdata,           // Write data
    input wire [7:0]  cfg_rdata_r,         // Read data
    input wire        ref_loss_lock_mask,  // Reference-loss mask
    input wire        vcxo_loop_lock_loss, // VCXO loop lost lock
    input wire        sel_ref_inactive,    // Selected ref inactive
    input wire        lock_fail_r,         // Lock failure
    input wire        sysref_power_down_r, // Power-down bit
    input wire [6:0]  sysref_divider_r,    // Divider field
    input wire [12:0] sysref_div_ratio_r,  // Total ratio
    input wire        sysref_gen_bit_r,    // Generator mode bit
    input wire        sysref_out_bit_r     // Output mode bit
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    function int rat(input [6:0] d);
        return (d[6] ? 4 : 2) * (2 << d[5:4]) * (2 << d[3:2]) * (d[1:0] + 2);
    endfunction

    sequence wr18_s;
        cfg_wr && cfg_addr == 7'h18;
    endsequence
    sequence rd18_s;
        cfg_rd && cfg_addr == 7'h18;
    endsequence
    sequence wr1c_s;
        cfg_wr && cfg_addr == 7'h1C;
    endsequence
    sequence rd1c_s;
        cfg_rd && cfg_addr == 7'h1C;
    endsequence

    lock_mask_a: assert property (
        ref_loss_lock_mask && !vcxo_loop_lock_loss |=> !lock_fail_r)
        else $error("masked ref loss failed lock");
    lock_ref_a: assert property (
        !ref_loss_lock_mask && sel_ref_inactive |=> lock_fail_r)
        else $error("ref loss missed");
    pd_write_a: assert property (
        wr18_s |=> sysref_power_down_r == $past(cfg_wdata[7]))
        else $error("power-down write lost");
    // Ratio still shows its reset value on the first edge after release
    div_ratio_a: assert property (
        $past(rst_b) |->
        sysref_div_ratio_r == rat($past(sysref_divider_r)))
        else $error("ratio wrong");
    div_hold_a: assert property (
        !cfg_wr |=> $stable(sysref_divider_r))
        else $error("divider moved");
    pd_read_a: assert property (
        rd18_s |=> cfg_rdata_r ==
        {$past(sysref_power_down_r), $past(sysref_divider_r)})
        else $error("read wrong");
    mode_write_a: assert property (
        wr1c_s |=> {sysref_gen_bit_r, sysref_out_bit_r} ==
        $past(cfg_wdata[1:0]))
        else $error("mode write lost");
    rsvd_read_a: assert property (
        rd1c_s |=> cfg_rdata_r[7:2] == 6'h00)
        else $error("reserved bits set");
endmodule // srcr_regs_monitor
bind srcr_regs srcr_regs_monitor mon_u (.*);

// ---- tb/srcr_regs_tb_top.sv ----
// Self-checking bench for the SYSREF control register bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
module srcr_regs_tb_top;
reg clk_sys = 0, rst_b = 0, cfg_wr = 0, cfg_rd = 0;
reg [6:0] cfg_addr = 0, ad;
reg [7:0] cfg_wdata = 0;
reg ref_loss_lock_mask = 0, vcxo_loop_lock_loss = 0, sel_ref_inactive = 0;
wire [7:0] cfg_rdata_r, sysref_pulse_count_r, phase_delay_r;
wire [6:0] sysref_divider_r, sync_r;
wire [12:0] sysref_div_ratio_r;
wire lock_fail_r, sysref_power_down_r, bias_sel_r, sysref_gen_bit_r;
wire sysref_out_bit_r, sysref_extra_bit_r;
reg [7:0] sh [0:127];
reg [31:0] rs = 32'h531E9010;
int err_count = 0, n_tests = 0, i;
srcr_regs dut_u (.*);
initial forever #20 clk_sys = ~clk_sys;
function [31:0] lf(input [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// Writable bits per address; unmapped places keep nothing
function [7:0] msk(input [6:0] a);
    msk = (a >= 7'h18 && a <= 7'h1B) ? 8'hFF : (a == 7'h1C) ? 8'h03
        : (a == 7'h70) ? 8'h80 : 8'h00;
endfunction
function int rat(input [6:0] d);
    return (d[6] ? 4 : 2) * (2 << d[5:4]) * (2 << d[3:2]) * (d[1:0] + 2);
endfunction
task wr(input [6:0] a, input [7:0] d);
    @(posedge clk_sys) #1;
    cfg_wr = 1; cfg_addr = a; cfg_wdata = d;
    @(posedge clk_sys) #1;
    cfg_wr = 0;
    if (msk(a) != 0) sh[a] = d & msk(a);
    `CHK({sysref_power_down_r, sysref_divider_r}, sh[7'h18])
    `CHK({bias_sel_r, sync_r, sysref_pulse_count_r}, {sh[25], sh[26]})
    `CHK({phase_delay_r, sysref_extra_bit_r}, {sh[27], sh[7'h70][7]})
    `CHK({sysref_gen_bit_r, sysref_out_bit_r}, sh[7'h1C][1:0])
    @(posedge clk_sys) #1;
    `CHK(sysref_div_ratio_r, rat(sh[24][6:0]))
endtask
task rd(input [6:0] a);
    @(posedge clk_sys) #1;
    cfg_rd = 1; cfg_addr = a;
    @(posedge clk_sys) #1;
    cfg_rd = 0;
    `CHK(cfg_rdata_r, sh[a])
endtask
task wrap_up;
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
// Whole run is a few hundred cycles; this margin is generous
initial begin #100000; err_count++; wrap_up; end
initial begin
    for (i = 0; i < 128; i++) sh[i] = 0;
    sh[7'h18] = 8'h2F; sh[7'h19] = 8'h80;
    repeat (10) @(posedge clk_sys);
    #1 rst_b = 1;
    for (i = 0; i < 8; i++) rd(7'h18 + i);
    rd(7'h70);
    // corner ratios 24, 5120 and 384
    wr(7'h18, 8'h81); wr(7'h18, 8'h7F); wr(7'h18, 8'h1D);
    for (i = 0; i < 60; i++) begin
        rs = lf(rs);
        ad = rs[3] ? 7'h70 : 7'h18 + rs[2:0];
        wr(ad, rs[15:8]);
        rd(ad);
    end
    for (i = 0; i < 8; i++) begin
        {ref_loss_lock_mask, vcxo_loop_lock_loss, sel_ref_inactive} = i[2:0];
        @(posedge clk_sys) #1;
        `CHK(lock_fail_r, i[1] | (~i[2] & i[0]))
    end
    wrap_up;
end
endmodule // srcr_regs_tb_top
